/* File: core/oscsel_pkg.sv */
// oscsel_pkg: register offsets, field positions, reset values, codes
// shared by the oscillator mode and clock select block.
package oscsel_pkg;

  // register indices on the plain register port
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_CONTROL_SECOND = 2'h1;
  localparam logic [1:0] ADDR_TUNING = 2'h2;

  // oscillator_control fields
  localparam int IDLE_BIT = 7;
  localparam int FREQ_LSB = 4;
  localparam int STARTUP_BIT = 3;
  localparam int FAST_STABLE_BIT = 2;
  localparam int CLKSEL_LSB = 0;

  // oscillator_control_second fields
  localparam int SEC_ACTIVE_BIT = 6;
  localparam int SEC_KEEP_BIT = 3;
  localparam int MED_STABLE_BIT = 1;
  localparam int MED_SELECT_BIT = 0;

  // oscillator_tuning fields
  localparam int LOWSRC_BIT = 7;
  localparam int SWMUL_BIT = 6;
  localparam int TRIM_LSB = 0;

  // configuration byte fields
  localparam int CFG_TWO_SPEED_BIT = 7;
  localparam int CFG_MULT_BIT = 4;

  // reset values
  localparam logic [2:0] FREQ_RESET = 3'h6;
  localparam logic [1:0] CLKSEL_RESET = 2'h0;
  localparam logic [5:0] TRIM_RESET = 6'h00;

  // primary oscillator configuration codes
  localparam logic [3:0] MODE_EXT_LOW_A = 4'hd;
  localparam logic [3:0] MODE_EXT_LOW_B = 4'hc;
  localparam logic [3:0] MODE_EXT_MED_A = 4'hb;
  localparam logic [3:0] MODE_EXT_MED_B = 4'ha;
  localparam logic [3:0] MODE_EXT_HIGH_A = 4'h5;
  localparam logic [3:0] MODE_EXT_HIGH_B = 4'h4;
  localparam logic [3:0] MODE_FAST_XTAL_MED = 4'h3;
  localparam logic [3:0] MODE_FAST_XTAL_HIGH = 4'h2;
  localparam logic [3:0] MODE_STD_XTAL = 4'h1;
  localparam logic [3:0] MODE_LOWPOWER_XTAL = 4'h0;
  localparam logic [2:0] MODE_RC_PREFIX = 3'h3;
  localparam logic [2:0] MODE_INT_PREFIX = 3'h4;

  // internal frequency select codes
  localparam logic [2:0] FREQ_16M = 3'h7;
  localparam logic [2:0] FREQ_8M = 3'h6;
  localparam logic [2:0] FREQ_500K = 3'h2;
  localparam logic [2:0] FREQ_250K = 3'h1;
  localparam logic [2:0] FREQ_31K = 3'h0;

  // system clock select codes
  localparam logic [1:0] CLKSEL_PRIMARY = 2'h0;
  localparam logic [1:0] CLKSEL_SECONDARY = 2'h1;

  // primary bias levels
  localparam logic [1:0] BIAS_LOW = 2'h0;
  localparam logic [1:0] BIAS_MED = 2'h1;
  localparam logic [1:0] BIAS_HIGH = 2'h2;

  // internal source encodings
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_MEDIUM = 2'h1;
  localparam logic [1:0] SRC_SLOW = 2'h2;

  // switch pause, counted in cycles of old and new source
  localparam logic [2:0] SWITCH_OLD_EDGES = 3'h2;
  localparam logic [2:0] SWITCH_NEW_EDGES = 3'h3;

  // system clock source actually running
  typedef enum logic [1:0] {
    OSCSEL_RUN_PRIMARY,
    OSCSEL_RUN_SECONDARY,
    OSCSEL_RUN_INTERNAL
  } oscsel_source_t;

  typedef enum logic [1:0] {
    OSCSEL_SW_IDLE,
    OSCSEL_SW_OLD,
    OSCSEL_SW_NEW
  } oscsel_switch_t;

endpackage

/* File: core/oscsel_top.sv */
// oscsel_top: oscillator mode decode, multiplier enable, internal
// frequency selection and glitch-free source switch control.
// assumes configuration byte and oscillator status inputs are stable
// and synchronous to clk; analog oscillators live outside.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module oscsel_top
  import oscsel_pkg::*;
#(
  parameter int DATA_WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  // configuration and events
  input wire logic [7:0] upperConfigByte,
  input wire logic secondaryDigitalInput,
  input wire logic secondaryRequested,
  input wire logic sleepExecute,
  // oscillator status from analog side
  input wire logic fastInternalStableIn,
  input wire logic mediumInternalStableIn,
  input wire logic startupTimerExpired,
  input wire logic oldSourceEdge,
  input wire logic newSourceEdge,
  input wire logic instrClock,
  // oscillator controls
  output logic [1:0] primaryBias,
  output logic multiplierEnable,
  output logic [2:0] internalFreqSelect,
  output logic [1:0] internalSource,
  output logic [5:0] rcTrimValue,
  output logic secondaryEnable,
  output logic [1:0] systemSource,
  output logic clockGate,
  output logic enterIdle,
  output logic enterSleep,
  // spare oscillator pins
  output logic spareOscPinAOut,
  output logic spareOscPinAOe,
  output logic spareOscPinsGpio
);

  initial begin
    if (DATA_WIDTH != 8) begin
      $error("oscsel_top supports only 8-bit registers");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic idleOnSleepSelect;
  logic [2:0] freqSel;
  logic [1:0] clkSel;
  logic startupTimerDone;
  logic secondaryKeepRunning;
  logic mediumInternalSelect;
  logic lowFreqSourceSelect;
  logic softwareMultiplierEnable;
  logic [5:0] trim;
  logic resetSeen;
  oscsel_source_t runSource;
  oscsel_source_t targetSource;
  oscsel_switch_t swState;
  logic [2:0] swCount;

  ////////////////////////////////////////////////////////////////////////
  // decode

  wire logic [3:0] oscMode = upperConfigByte[3:0];
  wire logic configMultiplierEnable = upperConfigByte[CFG_MULT_BIT];
  wire logic twoSpeedStartupConfig = upperConfigByte[CFG_TWO_SPEED_BIT];

  wire logic wrControl = regWrite && regAddr == ADDR_CONTROL;
  wire logic wrSecond = regWrite && regAddr == ADDR_CONTROL_SECOND;
  wire logic wrTuning = regWrite && regAddr == ADDR_TUNING;

  // external clock pairs, the even code of each is the clock-out one
  wire logic extLow = oscMode[3:1] == MODE_EXT_LOW_A[3:1];
  wire logic extMed = oscMode[3:1] == MODE_EXT_MED_A[3:1];
  wire logic extHigh = oscMode[3:1] == MODE_EXT_HIGH_A[3:1];
  wire logic extMode = extLow || extMed || extHigh;
  wire logic fastXtalMed = oscMode == MODE_FAST_XTAL_MED;
  wire logic fastXtalHigh = oscMode == MODE_FAST_XTAL_HIGH;
  wire logic stdXtal = oscMode == MODE_STD_XTAL;
  wire logic rcMode = oscMode[3:1] == MODE_RC_PREFIX;
  wire logic intMode = oscMode[3:1] == MODE_INT_PREFIX;
  wire logic clockOutVariant = (extMode || rcMode || intMode) && !oscMode[0];

  // bias by band: below 160 kHz low, up to 16 MHz medium, above high
  wire logic [1:0] next_bias =
    (extHigh || fastXtalHigh) ? BIAS_HIGH :
    (extMed || fastXtalMed || stdXtal || rcMode) ? BIAS_MED :
    BIAS_LOW;

  // multiplier only meaningful for 4-16 MHz inputs; internal mode gates it to 8 or 16 MHz, other modes rely on the user
  wire logic intMultOk = (freqSel == FREQ_16M) || (freqSel == FREQ_8M);
  wire logic next_mult =
    intMode ? (softwareMultiplierEnable && intMultOk) :
    (extMode || fastXtalMed || fastXtalHigh) ?
      (configMultiplierEnable || softwareMultiplierEnable) :
    (configMultiplierEnable || softwareMultiplierEnable);

  // low codes pick medium, fast/512 or slow source; the slow source
  // wins at the lowest code unless low-source select asks otherwise
  wire logic lowCode = freqSel <= FREQ_500K;
  wire logic lowestSlow = freqSel == FREQ_31K && !lowFreqSourceSelect;
  wire logic [1:0] next_low_freq_source_select =
    !lowCode ? SRC_FAST :
    lowestSlow ? SRC_SLOW :
    mediumInternalSelect ? SRC_MEDIUM :
    SRC_FAST;

  wire oscsel_source_t reqSource =
    clkSel[1] ? OSCSEL_RUN_INTERNAL :
    (clkSel == CLKSEL_SECONDARY) ? OSCSEL_RUN_SECONDARY :
    OSCSEL_RUN_PRIMARY;
  wire logic [1:0] next_clkSel = wrControl ? regWriteData[1:0] : clkSel;
  wire logic clkSelChange = wrControl && regWriteData[1:0] != clkSel;

  // keep-running only matters for a crystal secondary
  wire logic next_secEn = secondaryDigitalInput ? secondaryRequested :
    (secondaryKeepRunning || secondaryRequested);

  wire logic primaryRunning = runSource == OSCSEL_RUN_PRIMARY &&
    !intMode && swState == OSCSEL_SW_IDLE;
  wire logic next_startupDone = startupTimerExpired && primaryRunning;

  logic [7:0] readMux;
  assign readMux =
    (regAddr == ADDR_CONTROL) ?
      {idleOnSleepSelect, freqSel, startupTimerDone,
       fastInternalStableIn, clkSel} :
    (regAddr == ADDR_CONTROL_SECOND) ?
      {1'b0, runSource == OSCSEL_RUN_SECONDARY, 2'b00,
       secondaryKeepRunning, 1'b0, mediumInternalStableIn,
       mediumInternalSelect} :
    (regAddr == ADDR_TUNING) ?
      {lowFreqSourceSelect, softwareMultiplierEnable, trim} :
    8'h00;

  ////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge clk) begin
    if (reset) begin
      idleOnSleepSelect <= 1'b0;
      freqSel <= FREQ_RESET;
      clkSel <= CLKSEL_RESET;
      secondaryKeepRunning <= 1'b0;
      mediumInternalSelect <= 1'b0;
      lowFreqSourceSelect <= 1'b0;
      softwareMultiplierEnable <= 1'b0;
      trim <= TRIM_RESET;
    end else begin
      if (wrControl) begin
        idleOnSleepSelect <= regWriteData[IDLE_BIT];
        freqSel <= regWriteData[FREQ_LSB +: 3];
      end
      clkSel <= next_clkSel;
      if (wrSecond) begin
        secondaryKeepRunning <= regWriteData[SEC_KEEP_BIT];
        mediumInternalSelect <= regWriteData[MED_SELECT_BIT];
      end
      if (wrTuning) begin
        lowFreqSourceSelect <= regWriteData[LOWSRC_BIT];
        softwareMultiplierEnable <= regWriteData[SWMUL_BIT];
        trim <= regWriteData[TRIM_LSB +: 6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source switch sequencer: gate, old edges, new edges, release

  always_ff @(posedge clk) begin
    if (reset) begin
      runSource <= OSCSEL_RUN_PRIMARY;
      targetSource <= OSCSEL_RUN_PRIMARY;
      swState <= OSCSEL_SW_IDLE;
      swCount <= 3'h0;
    end else begin
      case (swState)
        OSCSEL_SW_IDLE: begin
          if (clkSelChange) begin
            targetSource <= wrControl && regWriteData[1] ?
              OSCSEL_RUN_INTERNAL :
              (regWriteData[1:0] == CLKSEL_SECONDARY ?
                OSCSEL_RUN_SECONDARY : OSCSEL_RUN_PRIMARY);
            swState <= OSCSEL_SW_OLD;
            swCount <= 3'h0;
          end else if (reqSource != runSource) begin
            targetSource <= reqSource;
            swState <= OSCSEL_SW_OLD;
            swCount <= 3'h0;
          end
        end
        OSCSEL_SW_OLD: begin
          if (oldSourceEdge) begin
            if (swCount == SWITCH_OLD_EDGES - 3'h1) begin
              runSource <= targetSource;
              swState <= OSCSEL_SW_NEW;
              swCount <= 3'h0;
            end else begin
              swCount <= swCount + 3'h1;
            end
          end
        end
        OSCSEL_SW_NEW: begin
          if (newSourceEdge) begin
            if (swCount == SWITCH_NEW_EDGES - 3'h1) begin
              swState <= OSCSEL_SW_IDLE;
              swCount <= 3'h0;
            end else begin
              swCount <= swCount + 3'h1;
            end
          end
        end
        default: begin
          swState <= OSCSEL_SW_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and outputs

  // reset value of the startup flag is taken from the config byte at
  // the first clock after reset release, not under the reset itself
  always_ff @(posedge clk) begin
    if (reset) begin
      resetSeen <= 1'b1;
      startupTimerDone <= 1'b0;
    end else begin
      resetSeen <= 1'b0;
      if (resetSeen) begin
        startupTimerDone <= twoSpeedStartupConfig;
      end else begin
        startupTimerDone <= next_startupDone;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regReadData <= 8'h00;
      primaryBias <= BIAS_LOW;
      multiplierEnable <= 1'b0;
      internalFreqSelect <= FREQ_RESET;
      internalSource <= SRC_FAST;
      rcTrimValue <= TRIM_RESET;
      secondaryEnable <= 1'b0;
      systemSource <= 2'h0;
      clockGate <= 1'b0;
      enterIdle <= 1'b0;
      enterSleep <= 1'b0;
      spareOscPinAOut <= 1'b0;
      spareOscPinAOe <= 1'b0;
      spareOscPinsGpio <= 1'b1;
    end else begin
      regReadData <= regRead ? readMux : 8'h00;
      primaryBias <= next_bias;
      multiplierEnable <= next_mult;
      internalFreqSelect <= freqSel;
      internalSource <= next_low_freq_source_select;
      rcTrimValue <= trim;
      secondaryEnable <= next_secEn;
      systemSource <= runSource;
      clockGate <= swState != OSCSEL_SW_IDLE;
      enterIdle <= sleepExecute && idleOnSleepSelect;
      enterSleep <= sleepExecute && !idleOnSleepSelect;
      spareOscPinAOut <= clockOutVariant && instrClock;
      spareOscPinAOe <= clockOutVariant;
      spareOscPinsGpio <= intMode && oscMode[0];
    end
  end

endmodule

`default_nettype wire

/* File: sim/oscsel_top_chk.sv */
// oscsel_top_chk: port-level timing checks for the clock select block.
// assumes a bind onto oscsel_top; its outputs are registered off clk.
`timescale 1ns/1ps
`default_nettype none
module oscsel_top_chk
  import oscsel_pkg::*;
(
  // clock, reset and register port
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  // configuration and events
  input wire logic [7:0] upperConfigByte,
  input wire logic sleepExecute,
  input wire logic newSourceEdge,
  input wire logic instrClock,
  // controls and pins
  input wire logic [1:0] primaryBias,
  input wire logic multiplierEnable,
  input wire logic [2:0] internalFreqSelect,
  input wire logic [1:0] systemSource,
  input wire logic clockGate,
  input wire logic enterIdle,
  input wire logic enterSleep,
  input wire logic spareOscPinAOut,
  input wire logic spareOscPinAOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  wire logic [3:0] mode = upperConfigByte[3:0];
  wire logic intMode = mode[3:1] == MODE_INT_PREFIX;
  wire logic biasKnown = mode inside {4'hd, 4'hc, 4'hb, 4'ha, 4'h5,
    4'h4, 4'h3, 4'h2};
  wire logic [1:0] biasExp = mode inside {4'hd, 4'hc} ? BIAS_LOW :
    mode inside {4'h5, 4'h4, 4'h2} ? BIAS_HIGH : BIAS_MED;
  // 1x and 01 map onto the running-source code
  wire logic [1:0] wantSrc = regWriteData[1] ? 2'h2 :
    {1'b0, regWriteData[0]};
  wire logic ctlWrite = regWrite && regAddr == ADDR_CONTROL;
  ////////////////////////////////////////////////////////////
  read_slot_a: assert property (
    !$past(regRead) |-> regReadData == 8'h00)
    else $error("read data outside its slot");
  sleep_kind_a: assert property (
    sleepExecute |=> enterIdle != enterSleep)
    else $error("sleep gave neither or both modes");
  bias_mode_a: assert property (
    biasKnown |=> primaryBias == $past(biasExp))
    else $error("bias does not match mode");
  cfg_mult_a: assert property (
    upperConfigByte[4] && !intMode |=> multiplierEnable)
    else $error("config multiplier bit not honoured");
  int_mult_a: assert property (
    $past(intMode) && intMode && multiplierEnable |->
      internalFreqSelect[2:1] == 2'h3 ||
      $past(internalFreqSelect[2:1]) == 2'h3)
    else $error("multiplier on below 8 MHz");
  pin_clock_a: assert property (
    spareOscPinAOe |-> spareOscPinAOut == $past(instrClock))
    else $error("spare pin not carrying instruction clock");
  switch_start_a: assert property (
    ctlWrite && !clockGate && wantSrc != systemSource |->
      ##[1:3] clockGate)
    else $error("source switch did not start");
  switch_end_a: assert property (
    $fell(clockGate) |-> $past(newSourceEdge) ||
      $past(newSourceEdge, 2))
    else $error("pause ended without new source edge");
  source_move_a: assert property (
    $changed(systemSource) |-> clockGate || $past(clockGate))
    else $error("source changed outside pause");
  reset_state_a: assert property (
    $fell(reset) |-> systemSource == CLKSEL_PRIMARY &&
      internalFreqSelect == FREQ_RESET)
    else $error("reset state wrong");
endmodule

bind oscsel_top oscsel_top_chk chk (.clk, .reset, .regAddr,
  .regWriteData, .regWrite, .regRead, .regReadData, .upperConfigByte,
  .sleepExecute, .newSourceEdge, .instrClock, .primaryBias,
  .multiplierEnable, .internalFreqSelect, .systemSource, .clockGate,
  .enterIdle, .enterSleep, .spareOscPinAOut, .spareOscPinAOe);
`default_nettype wire

/* File: sim/oscsel_osc_model.sv */
// oscsel_osc_model: stand-in for the oscillators and start-up timer.
// assumes the bench clock; source edges come as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module oscsel_osc_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // behaviour controls
  input wire logic slow,
  input wire logic fastOn,
  input wire logic mediumOn,
  // status towards the block
  output logic oldSourceEdge,
  output logic newSourceEdge,
  output logic fastInternalStableIn,
  output logic mediumInternalStableIn,
  output logic startupTimerExpired,
  output logic instrClock
);
  logic [5:0] count;
  logic [3:0] phase;
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= 6'h00;
      phase <= 4'h0;
    end else begin
      if (count != 6'h3f) count <= count + 6'h01;
      phase <= (phase >= (slow ? 4'h9 : 4'h2)) ? 4'h0 : phase + 4'h1;
    end
  end
  // slow sources space edges out to stretch the pause
  assign oldSourceEdge = phase == 4'h0;
  assign newSourceEdge = phase == 4'h1;
  assign startupTimerExpired = count > 6'h27;
  assign instrClock = phase[0];
  assign fastInternalStableIn = fastOn;
  assign mediumInternalStableIn = mediumOn;
endmodule
`default_nettype wire

/* File: sim/oscillator_mode_and_clock_select_bench.sv */
// bench: registers, modes, multiplier, sources and switching.
// assumes oscsel_top, the oscillator model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module oscillator_mode_and_clock_select_bench;
  import oscsel_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic sleepExecute = 1'b0;
  logic secondaryDigitalInput = 1'b0;
  logic secondaryRequested = 1'b0;
  logic slow = 1'b0;
  logic fastOn = 1'b1;
  logic mediumOn = 1'b0;
  logic rdSeen = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWriteData = 8'h00;
  logic [7:0] upperConfigByte = 8'h02;
  logic [7:0] regReadData, d;
  logic [1:0] primaryBias, internalSource, systemSource;
  logic [2:0] internalFreqSelect;
  logic [5:0] rcTrimValue;
  logic multiplierEnable, secondaryEnable, clockGate, enterIdle;
  logic enterSleep, spareOscPinAOut, spareOscPinAOe, spareOscPinsGpio;
  logic oldSourceEdge, newSourceEdge, instrClock, startupTimerExpired;
  logic fastInternalStableIn, mediumInternalStableIn;
  logic [7:0] expQ [$];
  logic [3:0] modes [5] = '{4'hc, 4'ha, 4'h4, 4'h3, 4'h2};
  logic [1:0] bias [5] = '{BIAS_LOW, BIAS_MED, BIAS_HIGH, BIAS_MED,
    BIAS_HIGH};
  int errors = 0, compares = 0, cycles = 0, seed = 72, i;
  oscsel_top dut (.*);
  oscsel_osc_model partner (.*);
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1'b0;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic settle;
    step;
    step;
  endtask
  // bounded: waits up to 8 steps for the gate to rise, then checks it has dropped by step 120
  task automatic waitSwitch;
    int n = 0;
    while (clockGate !== 1'b1 && n < 8) begin
      step;
      n++;
    end
    while (clockGate === 1'b1 && n < 120) begin
      step;
      n++;
    end
    chk({7'h0, clockGate}, 8'h00);
  endtask
  function automatic logic [1:0] srcExp(input logic [4:0] k);
    if (k[2:0] > 3'h2) return SRC_FAST;
    if (k[2:0] == 3'h0 && !k[4]) return SRC_SLOW;
    return k[3] ? SRC_MEDIUM : SRC_FAST;
  endfunction
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rdSeen && expQ.size() > 0) chk(regReadData, expQ.pop_front());
    rdSeen = regRead && !reset;
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (50) @(posedge clk);
    rd(ADDR_CONTROL, 8'h6c);
    rd(ADDR_TUNING, 8'h00);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    mediumOn <= 1'b1;
    wr(ADDR_CONTROL_SECOND, 8'hff);
    rd(ADDR_CONTROL_SECOND, 8'h0b);
    settle;
    chk({7'h0, secondaryEnable}, 8'h01);
    secondaryDigitalInput <= 1'b1;
    settle;
    chk({7'h0, secondaryEnable}, 8'h00);
    secondaryDigitalInput <= 1'b0;
    wr(ADDR_CONTROL_SECOND, 8'h00);
    settle;
    chk({7'h0, secondaryEnable}, 8'h00);
    repeat (4) begin
      d = $random(seed);
      wr(ADDR_CONTROL, {d[7:2], 2'h0});
      rd(ADDR_CONTROL, {d[7:4], 4'hc});
    end
    for (i = 0; i < 2; i++) begin
      wr(ADDR_CONTROL, {i[0], 7'h60});
      @(posedge clk);
      sleepExecute <= 1'b1;
      step;
      sleepExecute <= 1'b0;
      chk({6'h0, enterIdle, enterSleep}, {6'h0, i[0], !i[0]});
    end
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      upperConfigByte <= {4'h1, modes[i]};
      settle;
      chk({6'h0, primaryBias}, {6'h0, bias[i]});
      chk({7'h0, multiplierEnable}, 8'h01);
      chk({7'h0, spareOscPinAOe}, {7'h0, i < 3});
    end
    upperConfigByte <= 8'h03;
    wr(ADDR_TUNING, 8'h40);
    settle;
    chk({7'h0, multiplierEnable}, 8'h01);
    upperConfigByte <= 8'h18;
    wr(ADDR_CONTROL, 8'h50);
    settle;
    chk({6'h0, multiplierEnable, spareOscPinAOe}, 8'h01);
    wr(ADDR_CONTROL, 8'h70);
    settle;
    chk({7'h0, multiplierEnable}, 8'h01);
    wr(ADDR_TUNING, 8'h00);
    upperConfigByte <= 8'h19;
    settle;
    chk({6'h0, spareOscPinsGpio, multiplierEnable}, 8'h02);
    upperConfigByte <= 8'h02;
    wr(ADDR_CONTROL, 8'h62);
    waitSwitch;
    chk({6'h0, systemSource}, 8'h02);
    rd(ADDR_CONTROL, 8'h66);
    for (i = 0; i < 32; i++) begin
      wr(ADDR_CONTROL_SECOND, {7'h0, i[3]});
      wr(ADDR_TUNING, {i[4], 7'h00});
      wr(ADDR_CONTROL, {1'b0, i[2:0], 4'h2});
      settle;
      chk({5'h0, internalFreqSelect}, {5'h0, i[2:0]});
      chk({6'h0, internalSource}, {6'h0, srcExp(i[4:0])});
    end
    for (i = 0; i < 2; i++) begin
      d = i ? 8'h1f : 8'h20;
      wr(ADDR_TUNING, d);
      rd(ADDR_TUNING, d);
      settle;
      chk({2'h0, rcTrimValue}, d);
    end
    slow <= 1'b1;
    secondaryRequested <= 1'b1;
    wr(ADDR_CONTROL, 8'h71);
    waitSwitch;
    chk({6'h0, systemSource}, 8'h01);
    rd(ADDR_CONTROL_SECOND, 8'h43);
    @(posedge clk);
    reset <= 1'b1;
    secondaryRequested <= 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle;
    chk({6'h0, systemSource}, 8'h00);
    rd(ADDR_CONTROL, 8'h64);
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule
`default_nettype wire
